// [bcc_engine.sv]
/*
  Cipher control engine behind an SPI slave: SRAM-window decode, fast
  read-while-write transfer, chaining, launch, completion and error status.
  Assumes an SPI mode 0 master on sclk/csN/mosi and power-state levels
  that come from logic on clk.
*/
// Overview of operation
// - Chaining XORs new block with previous result.
// - Decrypt only in codebook; chaining needs encrypt.
// - Launch bit write at alias starts operation.
// - Operation lasts about 23.4 us.
// - Done reads 0 pending, 1 within 24 us.
// - Fast write returns old byte one byte later.
// - Fast transfer applies to every window write.
// - Data writes overwrite the previous result.
// - Window maps to key in mode 1.
// - Mode field 6:4: codebook, key, chaining.
// - Error on control access during operation, refused launch or short read.
// - Control access during operation stops it.
// - Launch bit is write-only, reads zero.
// - Alias location behaves exactly like control.
// - Deepest power-down returns registers to reset.
// - Reachable only through SRAM-type accesses.
// - Key reads give last round key after encryption, first after decryption.
// - Access refused in sleep, power-down, reset.
`timescale 1ns/1ps
module bcc_engine #(
  parameter int OP_CYCLES = bcc_pkg::OP_CYCLES      // cycles of one cipher operation
) (
  input  wire logic clk,            // system clock, 250 MHz
  input  wire logic resetn,         // asynchronous reset, active low
  input  wire logic sclk,           // SPI clock from the host
  input  wire logic csN,            // SPI chip select, active low
  input  wire logic mosi,           // SPI data from the host
  output logic      miso,           // SPI data to the host
  input  wire logic sleepState,     // transceiver sleep state, blocks access
  input  wire logic deepPowerDown,  // deepest power-down state, clears registers
  output logic      engineBusy      // high while an operation runs
);
  // SPI link domain.
  logic       frameIdle;
  logic [2:0] bitCnt;
  logic [6:0] shiftIn;
  logic [7:0] rxByte;
  logic       rxToggle;
  logic [7:0] txShift;
  logic [7:0] txByte;

  assign frameIdle = csN | ~resetn;

  always_ff @(posedge sclk or posedge frameIdle) begin
    if (frameIdle) begin
      bitCnt <= 3'h0;
      shiftIn <= 7'h00;
    end else begin
      bitCnt <= bitCnt + 3'h1;
      shiftIn <= {shiftIn[5:0], mosi};
    end
  end

  // The received byte and its toggle survive the frame so the clk side can finish with them.
  always_ff @(posedge sclk or negedge resetn) begin
    if (!resetn) begin
      rxByte <= 8'h00;
      rxToggle <= 1'b0;
    end else if (!csN && bitCnt == 3'h7) begin
      rxByte <= {shiftIn, mosi};
      rxToggle <= ~rxToggle;
    end
  end

  // The answer byte is settled on clk a few ns after the toggle, well before this falling edge.
  always_ff @(negedge sclk or posedge frameIdle) begin
    if (frameIdle) begin
      txShift <= 8'h00;
      miso <= 1'b0;
    end else if (bitCnt == 3'h0) begin
      txShift <= {txByte[6:0], 1'b0};
      miso <= txByte[7];
    end else begin
      txShift <= {txShift[6:0], 1'b0};
      miso <= txShift[7];
    end
  end

  // Crossings into clk.
  logic [2:0] rxSync;
  logic [2:0] csSync;
  logic       rxEvt;
  logic       frameEnd;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rxSync <= 3'h0;
      csSync <= 3'h7;
    end else begin
      rxSync <= {rxSync[1:0], rxToggle};
      csSync <= {csSync[1:0], csN};
    end
  end

  assign rxEvt    = rxSync[2] ^ rxSync[1];
  assign frameEnd = csSync[1] & ~csSync[2];

  // Register state.
  bcc_pkg::bcc_eng_e engState;
  logic [2:0]   mode;
  logic         dir;
  logic         doneFlag;
  logic         errFlag;
  logic [127:0] dataState;
  logic [127:0] keyInit;
  logic [127:0] keyView;
  logic [127:0] prevResult;
  logic [127:0] opIn;
  logic         opDir;
  logic [12:0]  runCnt;
  logic [7:0]   cmd;
  logic [7:0]   ptr;
  logic [1:0]   byteIdx;
  logic [4:0]   rdCount;

  function automatic logic isCtrl(input logic [7:0] a);
    isCtrl = (a == bcc_pkg::ADDR_CTRL) || (a == bcc_pkg::ADDR_CTRL_ALIAS);
  endfunction : isCtrl

  function automatic logic isWin(input logic [7:0] a);
    isWin = (a >= bcc_pkg::ADDR_WIN_FIRST) && (a <= bcc_pkg::ADDR_WIN_LAST);
  endfunction : isWin

  // Byte 0x84 is the most significant byte of the 128-bit word.
  function automatic logic [6:0] winOffs(input logic [7:0] a);
    logic [3:0] idx;
    idx = 4'(a - bcc_pkg::ADDR_WIN_FIRST);
    winOffs = {~idx, 3'b000};
  endfunction : winOffs

  function automatic logic [7:0] readReg(input logic [7:0] a);
    readReg = 8'h00;
    if (a == bcc_pkg::ADDR_STATUS) begin
      readReg[bcc_pkg::STAT_DONE_BIT] = doneFlag;
      readReg[bcc_pkg::STAT_ERR_BIT] = errFlag;
    end else if (isCtrl(a)) begin
      readReg[bcc_pkg::CTRL_MODE_LSB +: 3] = mode;
      readReg[bcc_pkg::CTRL_DIR_BIT] = dir;
    end else if (isWin(a)) begin
      readReg = (mode == bcc_pkg::MODE_KEY) ? keyView[winOffs(a) +: 8] : dataState[winOffs(a) +: 8];
    end
  endfunction : readReg

  // Stand-in block transform with an invertible key schedule; encryption
  // returns the last round key, decryption takes it and returns the first.
  function automatic logic [255:0] coreRun(input logic [127:0] din, input logic [127:0] k, input logic dec);
    logic [127:0] x;
    logic [127:0] rk;
    x = din;
    rk = k;
    for (int i = 1; i <= bcc_pkg::CORE_ROUNDS; i++) begin
      if (!dec) begin
        rk = {rk[119:0], rk[127:120]} ^ 128'(i);
        x = {x[126:0], x[127]} ^ rk;
      end else begin
        x = x ^ rk;
        x = {x[0], x[127:1]};
        rk = rk ^ 128'(bcc_pkg::CORE_ROUNDS + 1 - i);
        rk = {rk[7:0], rk[127:8]};
      end
    end
    coreRun = {x, rk};
  endfunction : coreRun

  logic         accessOk;
  logic         isWrite;
  logic         isRead;
  logic         wrEvt;
  logic         rdEvt;
  logic         ctrlTouch;
  logic [255:0] coreOut;
  logic         modeOk;
  logic [2:0]   wrMode;

  assign accessOk  = ~sleepState & ~deepPowerDown;
  assign isWrite   = (cmd == bcc_pkg::CMD_SRAM_WRITE);
  assign isRead    = (cmd == bcc_pkg::CMD_SRAM_READ);
  assign wrEvt     = rxEvt & accessOk & isWrite & (byteIdx == 2'h2);
  assign rdEvt     = rxEvt & accessOk & isRead & (byteIdx != 2'h0);
  // A read touches a location only once its byte has been clocked out, so a status poll
  // that prefetches the control location for a byte that never comes does not stop a run.
  assign ctrlTouch = (wrEvt & isCtrl(ptr)) | (rdEvt & (byteIdx == 2'h2) & isCtrl(ptr));
  assign coreOut   = coreRun(opIn, keyInit, opDir);
  assign wrMode    = rxByte[bcc_pkg::CTRL_MODE_LSB +: 3];
  assign modeOk    = (wrMode == bcc_pkg::MODE_ECB) ||
                     (wrMode == bcc_pkg::MODE_CBC && rxByte[bcc_pkg::CTRL_DIR_BIT] == bcc_pkg::DIR_ENCRYPT);

  // Access protocol: command, address, then auto-incrementing data bytes.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cmd <= 8'hFF;
      ptr <= 8'h00;
      byteIdx <= 2'h0;
      txByte <= 8'h00;
      rdCount <= 5'h00;
    end else if (deepPowerDown || frameEnd) begin
      cmd <= 8'hFF;
      byteIdx <= 2'h0;
      txByte <= 8'h00;
      rdCount <= 5'h00;
    end else if (rxEvt && accessOk) begin
      if (byteIdx == 2'h0) begin
        cmd <= rxByte;
        byteIdx <= 2'h1;
      end else if (byteIdx == 2'h1) begin
        ptr <= rxByte;
        byteIdx <= 2'h2;
        txByte <= isRead ? readReg(rxByte) : 8'h00;
      end else begin
        ptr <= ptr + 8'h01;
        txByte <= isWrite ? readReg(ptr) : readReg(ptr + 8'h01);
      end
      if (isRead && byteIdx == 2'h2 && isWin(ptr) && mode != bcc_pkg::MODE_KEY) begin
        rdCount <= rdCount + 5'h01;
      end
    end
  end

  // Registers and the operation sequencer.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      engState <= bcc_pkg::ENG_IDLE;
      {mode, dir} <= 4'h0;
      doneFlag <= 1'b0;
      errFlag <= 1'b0;
      dataState <= 128'h0;
      keyInit <= 128'h0;
      keyView <= 128'h0;
      prevResult <= 128'h0;
      opIn <= 128'h0;
      opDir <= 1'b0;
      runCnt <= 13'h0;
      engineBusy <= 1'b0;
    end else if (deepPowerDown) begin
      engState <= bcc_pkg::ENG_IDLE;
      {mode, dir} <= 4'h0;
      doneFlag <= 1'b0;
      errFlag <= 1'b0;
      dataState <= 128'h0;
      keyInit <= 128'h0;
      keyView <= 128'h0;
      prevResult <= 128'h0;
      runCnt <= 13'h0;
      engineBusy <= 1'b0;
    end else begin
      if (wrEvt && isWin(ptr)) begin
        if (mode == bcc_pkg::MODE_KEY) begin
          keyInit[winOffs(ptr) +: 8] <= rxByte;
          keyView[winOffs(ptr) +: 8] <= rxByte;
        end else begin
          dataState[winOffs(ptr) +: 8] <= rxByte;
        end
      end
      if (wrEvt && isCtrl(ptr)) begin
        mode <= wrMode;
        dir <= rxByte[bcc_pkg::CTRL_DIR_BIT];
      end
      case (engState)
        bcc_pkg::ENG_IDLE: begin
          if (wrEvt && isCtrl(ptr) && rxByte[bcc_pkg::CTRL_REQ_BIT]) begin
            if (modeOk) begin
              opIn <= (wrMode == bcc_pkg::MODE_CBC) ? dataState ^ prevResult : dataState;
              opDir <= rxByte[bcc_pkg::CTRL_DIR_BIT];
              doneFlag <= 1'b0;
              errFlag <= 1'b0;
              runCnt <= 13'h0;
              engineBusy <= 1'b1;
              engState <= bcc_pkg::ENG_RUN;
            end else begin
              errFlag <= 1'b1;
            end
          end
        end
        bcc_pkg::ENG_RUN: begin
          if (ctrlTouch) begin
            errFlag <= 1'b1;
            engineBusy <= 1'b0;
            engState <= bcc_pkg::ENG_IDLE;
          end else if (runCnt == 13'(OP_CYCLES - 1)) begin
            dataState <= coreOut[255:128];
            prevResult <= coreOut[255:128];
            keyView <= coreOut[127:0];
            doneFlag <= 1'b1;
            engineBusy <= 1'b0;
            engState <= bcc_pkg::ENG_IDLE;
          end else begin
            runCnt <= runCnt + 13'h1;
          end
        end
        default: begin
          engineBusy <= 1'b0;
          engState <= bcc_pkg::ENG_IDLE;
        end
      endcase
      if (frameEnd && rdCount != 5'h00 && rdCount < 5'(bcc_pkg::BLOCK_BYTES)) begin
        errFlag <= 1'b1;
      end
    end
  end
endmodule : bcc_engine

// [bcc_engine_checker.sv]
/*
  Concurrent checks on the engine's top-level ports.
  Assumes binding to bcc_engine; SPI frames come from a host that leaves csN high between frames.
*/
`timescale 1ns/1ps
module bcc_engine_checker #(
  parameter int OP_CYCLES = 20        // cycles of one cipher operation
) (
  input wire logic clk,               // system clock
  input wire logic resetn,            // reset, active low
  input wire logic sclk,              // SPI clock
  input wire logic csN,               // chip select, active low
  input wire logic mosi,              // SPI data in
  input wire logic miso,              // SPI data out
  input wire logic sleepState,        // sleep level
  input wire logic deepPowerDown,     // deepest power-down level
  input wire logic engineBusy         // operation running
);
  int busyCnt;

  // Counts busy cycles so the length of a finished run can be measured.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      busyCnt <= 0;
    end else begin
      busyCnt <= engineBusy ? busyCnt + 1 : 0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  miso_idle_a: assert property (csN && $past(csN) |-> !miso)
    else $error("miso not low outside a frame");
  miso_edge_a: assert property ($changed(miso) |-> !sclk)
    else $error("miso changed while sclk high");
  busy_min_a: assert property ($rose(engineBusy) |-> (engineBusy || deepPowerDown) [*8])
    else $error("operation ended too early");
  op_length_a: assert property ($fell(engineBusy) && csN && !$past(deepPowerDown)
                                |-> busyCnt inside {[OP_CYCLES - 1 : OP_CYCLES + 1]})
    else $error("operation length wrong");
  sleep_block_a: assert property ($rose(engineBusy) |-> !$past(sleepState) && !$past(deepPowerDown))
    else $error("operation started while access blocked");
  deep_clear_a: assert property (deepPowerDown |=> !engineBusy)
    else $error("busy survived power-down");
  launch_frame_a: assert property ($rose(engineBusy) |-> !csN)
    else $error("operation started outside a frame");
  idle_quiet_a: assert property (csN [*8] |=> !$rose(engineBusy))
    else $error("operation started with no access");
endmodule : bcc_engine_checker

// [bcc_host.sv]
/*
  SPI master model of the host microcontroller, mode 0, MSB first.
  Assumes the bench fills tx, calls frame and reads rx; 125 ns per bit.
*/
`timescale 1ns/1ps
module bcc_host (
  output logic      sclk,   // SPI clock, still outside frames
  output logic      csN,    // chip select, active low
  output logic      mosi,   // data to the device
  input  wire logic miso    // data from the device
);
  logic [7:0] tx [0:19];
  logic [7:0] rx [0:19];

  initial begin
    sclk = 1'b0;
    mosi = 1'b0;
    // Raising select after time zero gives the link-side reset a clean edge.
    #0.5 csN = 1'b1;
  end

  // Only SRAM-type frames are ever sent.
  task automatic frame(input int n);
    csN = 1'b0;
    #62.5;
    for (int i = 0; i < n; i++) begin
      for (int b = 7; b >= 0; b--) begin
        mosi = tx[i][b];
        #62.5 sclk = 1'b1;
        rx[i][b] = miso;
        #62.5 sclk = 1'b0;
      end
    end
    #62.5 csN = 1'b1;
    // Inverting mosi after release keeps a stale bit from passing as valid.
    mosi = ~mosi;
    #250;
  endtask : frame
endmodule : bcc_host

// [bcc_pkg.sv]
/*
  Shared constants for the block-cipher control engine: SRAM-window addresses,
  field positions, reset values, mode codes and operation timing.
  Assumes a 250 MHz system clock and an SPI link clocked by the host.
*/
package bcc_pkg;
  // Window addresses reached through SRAM-type accesses.
  localparam logic [7:0] ADDR_STATUS     = 8'h82;
  localparam logic [7:0] ADDR_CTRL       = 8'h83;
  localparam logic [7:0] ADDR_WIN_FIRST  = 8'h84;
  localparam logic [7:0] ADDR_WIN_LAST   = 8'h93;
  localparam logic [7:0] ADDR_CTRL_ALIAS = 8'h94;
  // SPI command bytes for SRAM access.
  localparam logic [7:0] CMD_SRAM_WRITE  = 8'h40;
  localparam logic [7:0] CMD_SRAM_READ   = 8'h00;
  // Status fields.
  localparam int         STAT_DONE_BIT   = 0;
  localparam int         STAT_ERR_BIT    = 7;
  localparam logic [7:0] STATUS_RESET    = 8'h00;
  // Control fields.
  localparam int         CTRL_REQ_BIT    = 7;
  localparam int         CTRL_MODE_LSB   = 4;
  localparam int         CTRL_DIR_BIT    = 3;
  localparam logic [7:0] CTRL_RESET      = 8'h00;
  localparam logic [2:0] MODE_ECB        = 3'h0;
  localparam logic [2:0] MODE_KEY        = 3'h1;
  localparam logic [2:0] MODE_CBC        = 3'h2;
  localparam logic       DIR_ENCRYPT     = 1'b0;
  // Timing: one operation takes 23.4 us, completion is flagged by 24 us.
  localparam int         CLK_MHZ         = 250;
  localparam int         T_OP_NS         = 23400;
  localparam int         T_DONE_MAX_NS   = 24000;
  localparam int         OP_CYCLES       = (T_OP_NS * CLK_MHZ + 999) / 1000;
  localparam int         DONE_MAX_CYCLES = (T_DONE_MAX_NS * CLK_MHZ) / 1000;
  localparam int         CORE_ROUNDS     = 10;
  localparam int         BLOCK_BYTES     = 16;

  typedef enum logic {ENG_IDLE, ENG_RUN} bcc_eng_e;
endpackage : bcc_pkg

// [tb_top.sv]
/*
  Top bench: engine, host model and checker; tests are SPI access sequences.
  Assumes the host model in bcc_host and the checker bound below.
*/
`timescale 1ns/1ps
module tb_top;
  localparam int OPC = 2000;
  logic       clk, resetn, sclk, csN, mosi, miso;
  logic       sleepState, deepPowerDown, engineBusy;
  logic [7:0] c2 [0:15];
  logic [7:0] pt [0:15];
  int         fails, comparisons, cyc;
  logic [7:0] codes [0:3] = '{8'ha8, 8'hb0, 8'hf0, 8'h90};

  bcc_engine #(.OP_CYCLES(OPC)) uut (.clk(clk), .resetn(resetn), .sclk(sclk), .csN(csN), .mosi(mosi),
    .miso(miso), .sleepState(sleepState), .deepPowerDown(deepPowerDown), .engineBusy(engineBusy));
  bcc_host host (.sclk(sclk), .csN(csN), .mosi(mosi), .miso(miso));

  initial clk = 1'b0;
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc > 90000) begin
      fails++;
      stop_test();
    end
  end

  task automatic stop_test;
    if (fails == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input int n);
    host.tx[0] = 8'h40;
    host.tx[1] = a;
    host.frame(n + 2);
  endtask : wr
  task automatic rd(input logic [7:0] a, input int n);
    host.tx[0] = 8'h00;
    host.tx[1] = a;
    for (int k = 2; k < 20; k++) host.tx[k] = 8'h00;
    host.frame(n + 2);
  endtask : rd
  task automatic wr1(input logic [7:0] a, input logic [7:0] v);
    host.tx[2] = v;
    wr(a, 1);
  endtask : wr1
  task automatic fill(input logic [7:0] ctrl, input logic [7:0] s);
    host.tx[2] = ctrl;
    for (int k = 0; k < 16; k++) host.tx[3 + k] = s + 8'(k) * 8'h1d;
    host.tx[19] = ctrl | 8'h80;
  endtask : fill
  task automatic waitIdle;
    for (int i = 0; i < OPC + 100 && engineBusy === 1'b1; i++) @(posedge clk);
    chk("busy", 8'h00, {7'h00, engineBusy});
  endtask : waitIdle
  task automatic stat(input logic [7:0] e, input logic [7:0] m);
    rd(8'h82, 1);
    chk("status", e, host.rx[2] & m);
  endtask : stat

  initial begin
    resetn = 1'b1;
    sleepState = 1'b0;
    deepPowerDown = 1'b0;
    // Reset falls after time zero so every asynchronous reset sees a clean edge.
    #1 resetn = 1'b0;
    repeat (8) @(posedge clk);
    #1 resetn = 1'b1;
    repeat (3) @(posedge clk);
    rd(8'h82, 2);
    chk("status", 8'h00, host.rx[2]);
    chk("control", 8'h00, host.rx[3]);
    fill(8'h10, 8'h5a);
    wr(8'h83, 17);
    fill(8'h00, 8'h21);
    wr(8'h83, 17);
    fill(8'h00, 8'h37);
    wr(8'h83, 18);
    for (int k = 0; k < 16; k++) chk("lag", 8'h21 + 8'(k) * 8'h1d, host.rx[4 + k]);
    chk("busy", 8'h01, {7'h00, engineBusy});
    stat(8'h00, 8'hff);
    waitIdle();
    stat(8'h01, 8'hff);
    fill(8'h20, 8'h4c);
    wr(8'h83, 18);
    waitIdle();
    rd(8'h83, 1);
    chk("control", 8'h20, host.rx[2]);
    rd(8'h94, 1);
    chk("alias", 8'h20, host.rx[2]);
    fill(8'h00, 8'h4c);
    for (int k = 0; k < 16; k++) begin
      host.tx[3 + k] ^= host.rx[4 + k];
      pt[k] = host.tx[3 + k];
    end
    wr(8'h83, 18);
    for (int k = 0; k < 16; k++) c2[k] = host.rx[4 + k];
    waitIdle();
    rd(8'h84, 16);
    for (int k = 0; k < 16; k++) chk("chain", c2[k], host.rx[2 + k]);
    // Decrypting the chained result with the last round key must give back its input.
    wr1(8'h83, 8'h10);
    rd(8'h84, 16);
    fill(8'h10, 8'h00);
    for (int k = 0; k < 16; k++) host.tx[3 + k] = host.rx[2 + k];
    wr(8'h83, 17);
    fill(8'h08, 8'h00);
    for (int k = 0; k < 16; k++) host.tx[3 + k] = c2[k];
    wr(8'h83, 18);
    waitIdle();
    rd(8'h84, 16);
    for (int k = 0; k < 16; k++) chk("decrypt", pt[k], host.rx[2 + k]);
    for (int i = 0; i < 4; i++) begin
      wr1(8'h94, codes[i]);
      chk("busy", 8'h00, {7'h00, engineBusy});
      stat(8'h80, 8'h80);
    end
    wr1(8'h94, 8'h80);
    rd(8'h83, 1);
    chk("busy", 8'h00, {7'h00, engineBusy});
    stat(8'h80, 8'hff);
    wr1(8'h94, 8'h80);
    waitIdle();
    stat(8'h01, 8'hff);
    rd(8'h84, 4);
    stat(8'h80, 8'h80);
    @(posedge clk);
    #1 sleepState = 1'b1;
    wr1(8'h94, 8'h80);
    chk("busy", 8'h00, {7'h00, engineBusy});
    @(posedge clk);
    #1 sleepState = 1'b0;
    wr1(8'h83, 8'h28);
    @(posedge clk);
    #1 deepPowerDown = 1'b1;
    repeat (4) @(posedge clk);
    #1 deepPowerDown = 1'b0;
    repeat (3) @(posedge clk);
    rd(8'h82, 2);
    chk("status", 8'h00, host.rx[2]);
    chk("control", 8'h00, host.rx[3]);
    stop_test();
  end
endmodule : tb_top

bind bcc_engine bcc_engine_checker #(.OP_CYCLES(OP_CYCLES)) chk_i (.clk(clk), .resetn(resetn), .sclk(sclk),
  .csN(csN), .mosi(mosi), .miso(miso), .sleepState(sleepState), .deepPowerDown(deepPowerDown),
  .engineBusy(engineBusy));
